/* File: rtl/epec_pkg.sv */
// Constants, types and address map of the EEPROM program/erase controller.
// Assumes a 16-bit CPU byte address carried on APB as a word index.

package epec_pkg;

  // ----------------------------------------------------------------------
  // Bus and address map
  // ----------------------------------------------------------------------
  localparam int          PADDR_W   = 18;     // APB byte address width
  localparam int          ADDR_W    = 16;     // CPU address width
  localparam int          ADDR_LSB  = 2;      // One register per word
  localparam int          DATA_W    = 32;
  localparam logic [15:0] ARR_BASE  = 16'h0600;
  localparam logic [15:0] ARR_LAST  = 16'h07FF;
  localparam int          ARR_BYTES = 512;
  localparam int          IDX_W     = 9;
  localparam int          BLK_MSB   = 8;      // Block number is idx[8:7]
  localparam int          BLK_LSB   = 7;
  localparam int          GUARD_W   = 4;
  localparam logic [15:0] SEC_LO    = 16'h08F0;
  localparam logic [15:0] SEC_HI    = 16'h08FF;
  localparam logic [15:0] CTRL_IDX  = 16'h05F0;
  localparam logic [15:0] OPT_IDX   = 16'h05F1;
  localparam logic [15:0] SHD_IDX   = 16'h05F2;
  localparam logic [15:0] STAT_IDX  = 16'h05F3;

  // ----------------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------------
  localparam int          CTL_HV      = 0;    // hv_apply_enable
  localparam int          CTL_LATCH   = 1;    // bus_latch_enable
  localparam int          CTL_SEL_LO  = 2;    // erase_select_lo
  localparam int          CTL_SEL_HI  = 3;    // erase_select_hi
  localparam int          CTL_PCLK    = 4;    // Bus clock drives pump
  localparam int          OPT_LOCK    = 4;    // secure_lock_bit, 0 = armed
  localparam logic [7:0]  ERASED      = 8'hFF;
  localparam logic [7:0]  OPT_FRESH   = 8'h10; // Lock off, no guards
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] CNT_ONE     = 16'h0001;

  // Program/erase mode, indexed by {erase_select_hi, erase_select_lo}
  typedef enum logic [1:0] {
    MODE_PROG  = 2'b00,
    MODE_BYTE  = 2'b01,
    MODE_BLOCK = 2'b10,
    MODE_BULK  = 2'b11
  } epec_mode_e;

  // Latch/voltage sequence, Gray coded from idle up to voltage on
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_OPEN = 2'b01,
    SEQ_CAPT = 2'b11,
    SEQ_HV   = 2'b10
  } epec_seq_e;

  // Captured write
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } epec_cap_s;

endpackage : epec_pkg

/* File: rtl/epec_hv_drive.sv */
// Charge pump and high-voltage switch driver with an on-time counter.
// Assumes the request is a registered level from the sequence logic.

`timescale 1ns/1ps

module epec_hv_drive (
  input  wire logic        clock_i,     // Bus clock
  input  wire logic        rst_i,       // Synchronous reset, high
  input  wire logic        hv_req_i,    // Voltage wanted
  output logic             hv_on_o,     // Array high voltage applied
  output logic             pump_on_o,   // Charge pump running
  output logic [15:0]      hv_cycles_o  // Cycles since voltage applied
);
  import epec_pkg::*;

  // ----------------------------------------------------------------------
  // Pump and switch
  // ----------------------------------------------------------------------
  // R9 pump follows request
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hv_on_o   <= 1'b0;
      pump_on_o <= 1'b0;
    end else begin
      hv_on_o   <= hv_req_i;
      pump_on_o <= hv_req_i;
    end
  end

  // Saturating on-time count, lets software check its own wait
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hv_cycles_o <= 16'h0000;
    end else if (!hv_req_i) begin
      hv_cycles_o <= 16'h0000;
    end else if (hv_cycles_o != CNT_MAX) begin
      hv_cycles_o <= hv_cycles_o + CNT_ONE;
    end
  end

endmodule : epec_hv_drive

/* File: rtl/epec_top.sv */
// EEPROM program/erase controller: 512-byte array, option byte, shadow,
// latch/voltage interlocks and block and security protection, on APB.
// Assumes an APB master; each CPU byte address is one word on the bus.
//
// Function
// R1: Erased bytes read ones; program only clears bits; erase restores ones.
// R2: Only unprotected array bytes or the option byte are ever changed.
// R3: Software: select, latch, write, voltage on, wait, off, wait, unlatch.
// R4: Erase select zero means byte program; other codes erase.
// R5: While latched, valid array writes capture address and data, last wins.
// R6: While latched, array reads return the captured data.
// R7: While latched, control writes are ignored until a capture.
// R8: Voltage cannot be enabled without latch and captured write.
// R9: Voltage enable runs the pump and applies voltage; clearing stops both.
// R10: Clearing voltage and latch together clears only voltage.
// R11: Captured address picks byte, block or whole array to erase.
// R12: Erase mode is frozen while voltage is applied.
// R13: Block and bulk erase never touch the option byte.
// R14: Four 128-byte blocks; protected targets never get voltage.
// R15: Blocks ascend from 0600 to 07FF, each with its guard bit.
// R16: A set guard blocks its block's erase and any bulk erase.
// R17: Shadow loads from option byte at reset and each option read.
// R18: Delivered: array all ones, option lock bit one, no guards.
// R19: Armed lock blocks program/erase of 08F0 to 08FF; reads normal.
// R20: Armed lock blocks block, bulk and option changes; byte erase stays.
// R21: Armed lock: secured writes are not valid captures.
// R22: Armed lock is permanent and freezes the option byte.
// R23: Mode codes 00 program, 01 byte, 10 block, 11 bulk; guard overrides.
// R24: Option byte writes capture like array writes unless armed.
//
// The placing of the registers and the APB slave port are this design's own decisions.

`timescale 1ns/1ps

module epec_top (
  input  wire logic                         clock_i,        // 125 MHz
  input  wire logic                         rst_i,          // Sync reset
  input  wire logic                         factory_fill_i, // Delivery load
  input  wire logic                         psel_i,         // APB select
  input  wire logic                         penable_i,      // APB enable
  input  wire logic                         pwrite_i,       // APB write
  input  wire logic [epec_pkg::PADDR_W-1:0] paddr_i,        // APB address
  input  wire logic [epec_pkg::DATA_W-1:0]  pwdata_i,       // APB wdata
  output logic                              pready_o,       // APB ready
  output logic [epec_pkg::DATA_W-1:0]       prdata_o,       // APB rdata
  output logic                              pslverr_o,      // Unmapped
  output logic                              hv_on_o,        // Voltage on
  output logic                              pump_on_o,      // Pump running
  output logic                              pump_bus_clk_o, // Pump clock
  output logic [7:0]                        config_o        // Shadow byte
);
  import epec_pkg::*;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic in_array(input logic [15:0] a);
    return (a >= ARR_BASE) && (a <= ARR_LAST);
  endfunction : in_array

  function automatic logic in_secured(input logic [15:0] a);
    return (a >= SEC_LO) && (a <= SEC_HI);
  endfunction : in_secured

  function automatic logic [IDX_W-1:0] idx_of(input logic [15:0] a);
    logic [15:0] off;
    off = a - ARR_BASE;
    return off[IDX_W-1:0];
  endfunction : idx_of

  function automatic logic [1:0] blk_of(input logic [IDX_W-1:0] i);
    return i[BLK_MSB:BLK_LSB];
  endfunction : blk_of

  // Whether voltage may be applied for this target and mode
  function automatic logic permitted(input logic [15:0]        a,
                                     input epec_mode_e         m,
                                     input logic [GUARD_W-1:0] g,
                                     input logic               armed);
    logic [1:0] b;
    b = blk_of(idx_of(a));
    if (a == OPT_IDX) begin
      // R20 option frozen when armed
      return !armed && (m == MODE_PROG || m == MODE_BYTE);
    end
    if (!in_array(a) || (armed && in_secured(a))) begin
      return 1'b0;
    end
    // R16 R23 guard overrides every mode
    unique case (m)
      MODE_PROG, MODE_BYTE: return !g[b];
      MODE_BLOCK: return !g[b] && !armed;
      MODE_BULK:  return (g == '0) && !armed;
    endcase
  endfunction : permitted

  // ----------------------------------------------------------------------
  // APB front
  // ----------------------------------------------------------------------
  logic                pready_q, pslverr_q;
  logic [DATA_W-1:0]   prdata_q;
  logic [ADDR_W-1:0]   cpu_addr;
  logic                first_acc, done, wr_done, rd_done;
  logic                hit_arr, hit_ctl, hit_opt, hit_shd, hit_sta;

  assign cpu_addr  = paddr_i[PADDR_W-1:ADDR_LSB];
  assign first_acc = psel_i & penable_i & ~pready_q;
  assign done      = psel_i & penable_i & pready_q;
  assign wr_done   = done & pwrite_i;
  assign rd_done   = done & ~pwrite_i;
  assign hit_arr   = in_array(cpu_addr);
  assign hit_ctl   = (cpu_addr == CTRL_IDX);
  assign hit_opt   = (cpu_addr == OPT_IDX);
  assign hit_shd   = (cpu_addr == SHD_IDX);
  assign hit_sta   = (cpu_addr == STAT_IDX);

  // ----------------------------------------------------------------------
  // Storage and sequence state
  // ----------------------------------------------------------------------
  logic [7:0]          mem_q [ARR_BYTES];
  logic [7:0]          opt_q, shd_q;
  logic                load_pend_q;
  epec_seq_e           seq_q;
  epec_mode_e          sel_q, wr_mode;
  logic                pclk_q;
  epec_cap_s           cap_q;
  logic                armed, valid_wr, ctl_open, go_hv, cap_arr;
  logic [IDX_W-1:0]    cap_idx;
  logic [15:0]         hv_cycles;
  logic [DATA_W-1:0]   rdata;

  // Lock lives in the option byte itself, so it cannot be undone
  // R22 lock is permanent
  assign armed   = ~opt_q[OPT_LOCK];
  assign cap_arr = in_array(cap_q.addr);
  assign cap_idx = idx_of(cap_q.addr);
  // A write that raises the voltage acts in the mode that it selects
  assign wr_mode = epec_mode_e'({pwdata_i[CTL_SEL_HI], pwdata_i[CTL_SEL_LO]});

  // R21 secured writes do not count
  // R24 option byte captures too
  assign valid_wr = wr_done &
                    ((hit_arr & ~(armed & in_secured(cpu_addr))) |
                     (hit_opt & ~armed));

  // R7 control locked until capture
  assign ctl_open = wr_done & hit_ctl & (seq_q != SEQ_OPEN);

  // R8 voltage only after capture
  // R14 protected target never gets voltage
  assign go_hv = ctl_open & (seq_q == SEQ_CAPT) & pwdata_i[CTL_HV] &
                 permitted(cap_q.addr, wr_mode, shd_q[GUARD_W-1:0], armed);

  // Latch and voltage sequence
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      seq_q <= SEQ_IDLE;
    end else if (ctl_open) begin
      unique case (seq_q)
        SEQ_IDLE: begin
          if (pwdata_i[CTL_LATCH]) begin
            seq_q <= SEQ_OPEN;
          end
        end
        SEQ_CAPT: begin
          if (go_hv) begin
            seq_q <= SEQ_HV;
          end else if (!pwdata_i[CTL_LATCH]) begin
            seq_q <= SEQ_IDLE;
          end
        end
        // R10 latch survives voltage clear
        SEQ_HV: begin
          if (!pwdata_i[CTL_HV]) begin
            seq_q <= SEQ_CAPT;
          end
        end
        default: begin
          seq_q <= seq_q;
        end
      endcase
    end else if (valid_wr && seq_q == SEQ_OPEN) begin
      seq_q <= SEQ_CAPT;
    end
  end

  // R12 mode frozen under voltage
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sel_q  <= MODE_PROG;
      pclk_q <= 1'b0;
    end else if (ctl_open && seq_q != SEQ_HV) begin
      sel_q  <= wr_mode;
      pclk_q <= pwdata_i[CTL_PCLK];
    end
  end

  // R5 capture, last valid write wins
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cap_q <= '0;
    end else if (valid_wr && (seq_q == SEQ_OPEN || seq_q == SEQ_CAPT)) begin
      cap_q.addr <= cpu_addr;
      cap_q.data <= pwdata_i[7:0];
    end
  end

  // Array cells are nonvolatile: no reset, only the delivery load
  genvar g;
  generate
    for (g = 0; g < ARR_BYTES; g++) begin : g_cell
      logic [IDX_W-1:0] my_idx;
      logic             hit;
      assign my_idx = IDX_W'(g);
      // R11 byte, block or whole array
      // R15 block number from address
      assign hit = cap_arr &&
                   ((wr_mode == MODE_BULK) ||
                    (wr_mode == MODE_BLOCK &&
                     blk_of(my_idx) == blk_of(cap_idx)) ||
                    (wr_mode inside {MODE_PROG, MODE_BYTE} &&
                     my_idx == cap_idx));
      always_ff @(posedge clock_i) begin
        // R18 delivered erased
        if (factory_fill_i) begin
          mem_q[g] <= ERASED;
        // R2 only permitted targets change
        end else if (go_hv && hit) begin
          // R1 program clears, erase sets
          // R4 zero select programs
          mem_q[g] <= (wr_mode == MODE_PROG) ? (mem_q[g] & cap_q.data)
                                             : ERASED;
        end
      end
    end
  endgenerate

  // R13 block and bulk skip option
  // R20 no option change once armed
  always_ff @(posedge clock_i) begin
    if (factory_fill_i) begin
      opt_q <= OPT_FRESH;
    end else if (go_hv && cap_q.addr == OPT_IDX) begin
      opt_q <= (wr_mode == MODE_PROG) ? (opt_q & cap_q.data) : ERASED;
    end
  end

  // R17 shadow reload at reset and on option read
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      load_pend_q <= 1'b1;
      shd_q       <= BYTE_ZERO;
    end else begin
      load_pend_q <= 1'b0;
      if (load_pend_q || (rd_done && hit_opt)) begin
        shd_q <= opt_q;
      end
    end
  end

  epec_hv_drive u_hv (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .hv_req_i    (seq_q == SEQ_HV),
    .hv_on_o     (hv_on_o),
    .pump_on_o   (pump_on_o),
    .hv_cycles_o (hv_cycles)
  );

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // R6 latched reads see captured data
  // R19 secured bytes read normally
  always_comb begin
    rdata = '0;
    if (hit_arr) begin
      rdata[7:0] = (seq_q != SEQ_IDLE) ? cap_q.data
                                       : mem_q[idx_of(cpu_addr)];
    end else if (hit_ctl) begin
      rdata[CTL_HV]     = (seq_q == SEQ_HV);
      rdata[CTL_LATCH]  = (seq_q != SEQ_IDLE);
      rdata[CTL_SEL_LO] = sel_q[0];
      rdata[CTL_SEL_HI] = sel_q[1];
      rdata[CTL_PCLK]   = pclk_q;
    end else if (hit_opt) begin
      rdata[7:0] = opt_q;
    end else if (hit_shd) begin
      rdata[7:0] = shd_q;
    end else if (hit_sta) begin
      rdata[15:0] = hv_cycles;
    end
  end

  // One wait state so every bus output is a flop
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= first_acc;
      if (first_acc) begin
        prdata_q  <= pwrite_i ? '0 : rdata;
        pslverr_q <= ~(hit_arr | hit_ctl | hit_opt | hit_shd | hit_sta);
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  assign pready_o       = pready_q;
  assign prdata_o       = prdata_q;
  assign pslverr_o      = pslverr_q;
  assign pump_bus_clk_o = pclk_q;
  assign config_o       = shd_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_hv_after_capt: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(seq_q == SEQ_HV) |-> $past(seq_q) == SEQ_CAPT) // R8
    else $error("voltage applied without capture");

  a_latch_kept: assert property (@(posedge clock_i) disable iff (rst_i)
    seq_q == SEQ_HV && wr_done && hit_ctl && !pwdata_i[CTL_HV]
    |=> seq_q == SEQ_CAPT) // R10
    else $error("latch lost when clearing voltage");

  a_open_ignore: assert property (@(posedge clock_i) disable iff (rst_i)
    seq_q == SEQ_OPEN && wr_done && hit_ctl |=> seq_q == SEQ_OPEN) // R7
    else $error("control write taken before capture");

  a_mode_frozen: assert property (@(posedge clock_i) disable iff (rst_i)
    seq_q == SEQ_HV |=> sel_q == $past(sel_q)) // R12
    else $error("erase mode changed under voltage");

  a_prog_clears: assert property (@(posedge clock_i) disable iff (rst_i)
    !factory_fill_i && go_hv && wr_mode == MODE_PROG
    |=> (opt_q & ~$past(opt_q)) == BYTE_ZERO) // R1
    else $error("program set an option bit");

  a_opt_untouched: assert property (@(posedge clock_i) disable iff (rst_i)
    !factory_fill_i && go_hv && wr_mode inside {MODE_BLOCK, MODE_BULK}
    |=> $stable(opt_q)) // R13
    else $error("block or bulk erase changed option");

  a_guard_blocks: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(seq_q == SEQ_HV) && cap_arr |-> !shd_q[blk_of(cap_idx)]) // R14
    else $error("voltage on a guarded block");

  a_shadow_load: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_done && hit_opt |=> shd_q == $past(opt_q)) // R17
    else $error("shadow not reloaded on option read");

  a_latched_read: assert property (@(posedge clock_i) disable iff (rst_i)
    first_acc && !pwrite_i && hit_arr && seq_q != SEQ_IDLE
    ##1 pready_o |-> prdata_o[7:0] == cap_q.data) // R6
    else $error("latched read returned stored byte");

  a_capture_addr: assert property (@(posedge clock_i) disable iff (rst_i)
    valid_wr && seq_q inside {SEQ_OPEN, SEQ_CAPT}
    |=> cap_q.addr == $past(cpu_addr)) // R5
    else $error("valid write not captured");

  a_lock_stays: assert property (@(posedge clock_i) disable iff (rst_i)
    armed && !factory_fill_i |=> armed) // R22
    else $error("security lock released");

endmodule : epec_top

/* File: testbench/epec_cpu.sv */
// Processor-side bus model: an APB master for byte-wide reads and writes,
// plus the software program/erase sequence built on top of it.
// Assumes the controller answers every transfer with pready.

`timescale 1ns/1ps

module epec_cpu (
  input  wire logic                        clock_i,   // Bus clock
  input  wire logic                        hv_i,      // Voltage seen
  input  wire logic                        pready_i,  // APB ready
  input  wire logic [epec_pkg::DATA_W-1:0] prdata_i,  // APB rdata
  input  wire logic                        pslverr_i, // APB error
  output logic                             psel_o,    // APB select
  output logic                             penable_o, // APB enable
  output logic                             pwrite_o,  // APB write
  output logic [epec_pkg::PADDR_W-1:0]     paddr_o,   // APB address
  output logic [epec_pkg::DATA_W-1:0]      pwdata_o   // APB wdata
);
  import epec_pkg::*;

  // Idle bus at time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = '0;
    pwdata_o = '0;
  end

  // One transfer; a fresh edge first, so a strobe is never set twice
  task automatic xfer(input logic wr, input logic [15:0] a,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic err);
    @(posedge clock_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= {a, 2'b00};
    pwdata_o <= {24'h000000, d};
    @(posedge clock_i);
    penable_o <= 1'b1;
    do @(posedge clock_i); while (pready_i !== 1'b1);
    q = prdata_i[7:0];
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released lines show no stale value
    paddr_o <= ~paddr_o;
    pwdata_o <= ~pwdata_o;
  endtask : xfer

  task automatic put(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       e;
    xfer(1'b1, a, d, q, e);
  endtask : put

  task automatic op(input logic [1:0] m, input logic [15:0] a,
                    input logic [7:0] d, output logic h);
    put(CTRL_IDX, {4'h0, m, 2'b10});
    put(a, d);
    put(CTRL_IDX, {4'h0, m, 2'b11});
    @(posedge clock_i);
    #1;
    h = hv_i;
    put(CTRL_IDX, {4'h0, m, 2'b10});
    put(CTRL_IDX, 8'h00);
  endtask : op

endmodule : epec_cpu

/* File: testbench/epec_top_tb.sv */
// Self-checking bench for the EEPROM program/erase controller.
// Assumes the processor bus model drives every APB input.

`timescale 1ns/1ps

`define CK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module epec_top_tb;
  import epec_pkg::*;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic [15:0] a;
    logic [7:0]  q;
    logic        err;
  } epec_row_s;

  logic                clock_i;
  logic                rst_i;
  logic                factory_fill_i;
  logic                psel, penable, pwrite, pready, pslverr;
  logic                hv_on_o, pump_on_o, pump_bus_clk_o;
  logic [PADDR_W-1:0]  paddr;
  logic [DATA_W-1:0]   pwdata, prdata;
  logic [7:0]          config_o, v;
  logic                h, e;
  int                  failures = 0;
  int                  n_tests = 0;

  localparam epec_row_s ROWS [8] = '{
    '{1'b0, 16'h0600, 8'hFF, 1'b0}, '{1'b0, 16'h07FF, 8'hFF, 1'b0},
    '{1'b0, OPT_IDX, 8'h10, 1'b0},  '{1'b1, SHD_IDX, 8'h00, 1'b0},
    '{1'b0, SHD_IDX, 8'h10, 1'b0},  '{1'b0, CTRL_IDX, 8'h00, 1'b0},
    '{1'b1, 16'h0000, 8'h00, 1'b1}, '{1'b0, 16'h0000, 8'h00, 1'b1}};

  epec_top i_epec_top (.clock_i(clock_i), .rst_i(rst_i),
    .factory_fill_i(factory_fill_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .hv_on_o(hv_on_o), .pump_on_o(pump_on_o),
    .pump_bus_clk_o(pump_bus_clk_o), .config_o(config_o));

  epec_cpu i_epec_cpu (.clock_i(clock_i), .hv_i(hv_on_o),
    .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    i_epec_cpu.put(a, d);
  endtask : put

  task automatic get(input logic [15:0] a, input logic [7:0] x);
    logic [7:0] q;
    logic       err;
    i_epec_cpu.xfer(1'b0, a, 8'h00, q, err);
    `CK(q, x)
  endtask : get

  task automatic op(input logic [1:0] m, input logic [15:0] a,
                    input logic [7:0] d, input logic x);
    logic hv;
    i_epec_cpu.op(m, a, d, hv);
    `CK(hv, x)
  endtask : op

  // Option read reloads the shadow on its completing edge; checked one edge later
  task automatic opt(input logic [7:0] x);
    get(OPT_IDX, x);
    @(posedge clock_i);
    #1;
    `CK(config_o, x)
  endtask : opt

  task automatic complete_run;
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // Whole run is well under a thousand cycles; this is generous
  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    complete_run();
  end

  initial begin
    rst_i = 1'b1;
    factory_fill_i = 1'b0;
    repeat (2) @(posedge clock_i);
    factory_fill_i <= 1'b1;
    @(posedge clock_i);
    factory_fill_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    `CK(config_o, OPT_FRESH)
    `CK({hv_on_o, pump_on_o, pump_bus_clk_o}, 3'b000)
    foreach (ROWS[i]) begin
      i_epec_cpu.xfer(ROWS[i].wr, ROWS[i].a, 8'h00, v, e);
      `CK(e, ROWS[i].err)
      if (!ROWS[i].wr)
        `CK(v, ROWS[i].q)
    end
    put(CTRL_IDX, 8'h02);
    put(CTRL_IDX, 8'h00);
    get(CTRL_IDX, 8'h02);
    // last capture wins, reads give it
    put(16'h0601, 8'h00);
    put(16'h0600, 8'hA5);
    get(16'h0700, 8'hA5);
    put(CTRL_IDX, 8'h03);
    @(posedge clock_i);
    #1;
    `CK({hv_on_o, pump_on_o}, 2'b11)
    // mode frozen, joint clear drops voltage only
    put(CTRL_IDX, 8'h0F);
    get(STAT_IDX, 8'h07);
    get(CTRL_IDX, 8'h03);
    put(CTRL_IDX, 8'h00);
    get(CTRL_IDX, 8'h02);
    `CK({hv_on_o, pump_on_o}, 2'b00)
    put(CTRL_IDX, 8'h00);
    get(16'h0600, 8'hA5);
    get(16'h0601, 8'hFF);
    op(2'b00, 16'h0600, 8'h0F, 1'b1);
    get(16'h0600, 8'h05);
    op(2'b00, 16'h0680, 8'h00, 1'b1);
    op(2'b00, 16'h0700, 8'h00, 1'b1);
    op(2'b01, 16'h0600, 8'h00, 1'b1);
    get(16'h0600, 8'hFF);
    op(2'b10, 16'h06A3, 8'h00, 1'b1);
    get(16'h0680, 8'hFF);
    get(16'h0700, 8'h00);
    op(2'b11, 16'h07FF, 8'h00, 1'b1);
    get(16'h0700, 8'hFF);
    opt(8'h10);
    put(CTRL_IDX, 8'h01);
    @(posedge clock_i);
    #1;
    `CK(hv_on_o, 1'b0)
    get(CTRL_IDX, 8'h00);
    put(CTRL_IDX, 8'h10);
    @(posedge clock_i);
    #1;
    `CK(pump_bus_clk_o, 1'b1)
    put(CTRL_IDX, 8'h00);
    op(2'b01, OPT_IDX, 8'h00, 1'b1);
    `CK(config_o, 8'h10)
    opt(8'hFF);
    op(2'b00, 16'h0600, 8'h00, 1'b0);
    get(16'h0600, 8'hFF);
    op(2'b11, 16'h0600, 8'h00, 1'b0);
    op(2'b00, OPT_IDX, 8'hFE, 1'b1);
    opt(8'hFE);
    op(2'b00, 16'h0600, 8'h3C, 1'b1);
    get(16'h0600, 8'h3C);
    op(2'b00, 16'h0680, 8'h00, 1'b0);
    op(2'b10, 16'h0600, 8'h00, 1'b1);
    get(16'h0600, 8'hFF);
    op(2'b11, 16'h0600, 8'h00, 1'b0);
    op(2'b00, OPT_IDX, 8'hEE, 1'b1);
    opt(8'hEE);
    op(2'b01, OPT_IDX, 8'h00, 1'b0);
    opt(8'hEE);
    op(2'b10, 16'h0600, 8'h00, 1'b0);
    put(CTRL_IDX, 8'h02);
    put(OPT_IDX, 8'h00);
    put(CTRL_IDX, 8'h00);
    get(CTRL_IDX, 8'h02);
    put(16'h0600, 8'h00);
    put(CTRL_IDX, 8'h00);
    op(2'b00, 16'h0600, 8'h00, 1'b1);
    op(2'b01, 16'h0600, 8'h00, 1'b1);
    get(16'h0600, 8'hFF);
    // mid-run reset reloads shadow, lock stays armed
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    `CK(config_o, BYTE_ZERO)
    repeat (2) @(posedge clock_i);
    #1;
    `CK(config_o, 8'hEE)
    op(2'b11, 16'h0600, 8'h00, 1'b0);
    complete_run();
  end

endmodule : epec_top_tb
